// ### jtp_tap.sv
/*
 * test access port: tap controller, instruction register, passthrough,
 * identification and boundary registers, serial output and pin control.
 * assumes test pins are asynchronous and much slower than clock (tck >= 100 ns).
 */
// Overview of operation
// - five tms-high edges reach test-logic-reset
// - transitions on rising tck, tms chooses
// - test-logic-reset disables all test logic
// - run-test-idle idle for these instructions
// - capture-ir loads pattern ending 01
// - shift-ir shifts instruction stages each rising edge
// - pause-ir holds instruction stages
// - update-ir latches on falling tck
// - capture-dr loads selected data register
// - data path mirrors instruction path
// - four-bit instruction, lsb nearest output
// - three data registers share serial path
// - passthrough stage captures zero
// - passthrough leaves device function alone
// - boundary chain reads and drives pins
// - identification 32 bits, read only
// - version, part, maker, bit0 one
// - decode 0,1,2,3,f instructions
// - high-z disables outputs, selects passthrough
// - external test drives and captures pins
`timescale 1ns/1ns
module jtp_tap #(
    parameter int          CELLS      = 8,
    parameter logic [3:0]  ID_VERSION = 4'h1,    // arbitrary value
    parameter logic [15:0] ID_PART    = 16'h1234, // arbitrary value
    parameter logic [10:0] ID_MAKER   = 11'h055   // arbitrary value
) (
    input  wire logic             clock,
    input  wire logic             rst_n,
    input  wire logic             tck,
    input  wire logic             tms,
    input  wire logic             tdi,
    input  wire logic             trst_n,
    input  wire logic [CELLS-1:0] core_out,
    input  wire logic [CELLS-1:0] core_oe,
    input  wire logic [CELLS-1:0] pin_in,
    output logic                  tdo,
    output logic                  tdo_oe_n,
    output logic      [CELLS-1:0] pin_out,
    output logic      [CELLS-1:0] pin_oe_n,
    output logic      [CELLS-1:0] core_in,
    output logic                  test_active
);
    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic tck_r, tck_f;
    logic tms_s, tdi_s, trst_s;

    jtp_sync u_tck (.clock(clock), .rst_n(rst_n), .async_in(tck), .reset_val(1'b0),
                    .level(), .rise(tck_r), .fall(tck_f));
    jtp_sync u_tms (.clock(clock), .rst_n(rst_n), .async_in(tms), .reset_val(1'b0),
                    .level(tms_s), .rise(), .fall());
    jtp_sync u_tdi (.clock(clock), .rst_n(rst_n), .async_in(tdi), .reset_val(1'b0),
                    .level(tdi_s), .rise(), .fall());
    jtp_sync u_trst (.clock(clock), .rst_n(rst_n), .async_in(trst_n), .reset_val(1'b0),
                     .level(trst_s), .rise(), .fall());

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    function automatic jtp_pkg::jtp_sel_t sel_of(input logic [3:0] insn);
        case (insn)
            jtp_pkg::INSN_EXT_TEST: sel_of = jtp_pkg::SEL_BOUNDARY;
            jtp_pkg::INSN_SAMPLE:   sel_of = jtp_pkg::SEL_BOUNDARY;
            jtp_pkg::INSN_IDENTIFY: sel_of = jtp_pkg::SEL_IDENT;
            default:                sel_of = jtp_pkg::SEL_PASSTHRU;
        endcase
    endfunction

    function automatic jtp_pkg::jtp_state_t next_of(input jtp_pkg::jtp_state_t s, input logic m);
        case (s)
            jtp_pkg::TS_RESET:   next_of = m ? jtp_pkg::TS_RESET   : jtp_pkg::TS_IDLE;
            jtp_pkg::TS_IDLE:    next_of = m ? jtp_pkg::TS_SEL_DR  : jtp_pkg::TS_IDLE;
            jtp_pkg::TS_SEL_DR:  next_of = m ? jtp_pkg::TS_SEL_IR  : jtp_pkg::TS_CAP_DR;
            jtp_pkg::TS_CAP_DR:  next_of = m ? jtp_pkg::TS_EX1_DR  : jtp_pkg::TS_SHF_DR;
            jtp_pkg::TS_SHF_DR:  next_of = m ? jtp_pkg::TS_EX1_DR  : jtp_pkg::TS_SHF_DR;
            jtp_pkg::TS_EX1_DR:  next_of = m ? jtp_pkg::TS_UPD_DR  : jtp_pkg::TS_PAU_DR;
            jtp_pkg::TS_PAU_DR:  next_of = m ? jtp_pkg::TS_EX2_DR  : jtp_pkg::TS_PAU_DR;
            jtp_pkg::TS_EX2_DR:  next_of = m ? jtp_pkg::TS_UPD_DR  : jtp_pkg::TS_SHF_DR;
            jtp_pkg::TS_UPD_DR:  next_of = m ? jtp_pkg::TS_SEL_DR  : jtp_pkg::TS_IDLE;
            jtp_pkg::TS_SEL_IR:  next_of = m ? jtp_pkg::TS_RESET   : jtp_pkg::TS_CAP_IR;
            jtp_pkg::TS_CAP_IR:  next_of = m ? jtp_pkg::TS_EX1_IR  : jtp_pkg::TS_SHF_IR;
            jtp_pkg::TS_SHF_IR:  next_of = m ? jtp_pkg::TS_EX1_IR  : jtp_pkg::TS_SHF_IR;
            jtp_pkg::TS_EX1_IR:  next_of = m ? jtp_pkg::TS_UPD_IR  : jtp_pkg::TS_PAU_IR;
            jtp_pkg::TS_PAU_IR:  next_of = m ? jtp_pkg::TS_EX2_IR  : jtp_pkg::TS_PAU_IR;
            jtp_pkg::TS_EX2_IR:  next_of = m ? jtp_pkg::TS_UPD_IR  : jtp_pkg::TS_SHF_IR;
            jtp_pkg::TS_UPD_IR:  next_of = m ? jtp_pkg::TS_SEL_DR  : jtp_pkg::TS_IDLE;
            default:             next_of = jtp_pkg::TS_RESET;
        endcase
    endfunction

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        jtp_pkg::jtp_state_t               st;
        logic [jtp_pkg::INSN_W-1:0]        ir_shf;
        logic [jtp_pkg::INSN_W-1:0]        ir_cur;
        logic                              pass;
        logic [jtp_pkg::IDENT_W-1:0]       ident;
        logic                              tdo;
        logic                              tdo_oe_n;
        logic [CELLS-1:0]                  pin_out;
        logic [CELLS-1:0]                  pin_oe_n;
        logic [CELLS-1:0]                  core_in;
        logic                              active;
    } jtp_tap_st_t;

    jtp_tap_st_t t_q;
    jtp_tap_st_t t_d;

    logic             bnd_out;
    logic [CELLS-1:0] bnd_upd;
    logic             bnd_cap, bnd_shf, bnd_upd_en;
    jtp_pkg::jtp_sel_t sel;
    logic             ext_test, high_z;
    logic [jtp_pkg::IDENT_W-1:0] ident_val;

    assign sel        = sel_of(t_q.ir_cur);
    assign ext_test   = (t_q.ir_cur == jtp_pkg::INSN_EXT_TEST) && (t_q.st != jtp_pkg::TS_RESET);
    assign high_z     = (t_q.ir_cur == jtp_pkg::INSN_HIGH_Z) && (t_q.st != jtp_pkg::TS_RESET);
    assign ident_val  = {ID_VERSION, ID_PART, ID_MAKER, jtp_pkg::ID_FIXED_BIT};
    assign bnd_cap    = tck_r && t_q.st == jtp_pkg::TS_CAP_DR && sel == jtp_pkg::SEL_BOUNDARY;
    assign bnd_shf    = tck_r && t_q.st == jtp_pkg::TS_SHF_DR && sel == jtp_pkg::SEL_BOUNDARY;
    assign bnd_upd_en = tck_f && t_q.st == jtp_pkg::TS_UPD_DR && sel == jtp_pkg::SEL_BOUNDARY;

    jtp_boundary #(.CELLS(CELLS)) u_bnd (
        .clock      (clock),
        .rst_n      (rst_n),
        .cap_en     (bnd_cap),
        .shf_en     (bnd_shf),
        .upd_en     (bnd_upd_en),
        .ser_in     (tdi_s),
        .pin_sample (ext_test ? pin_in : core_out),
        .ser_out    (bnd_out),
        .upd_val    (bnd_upd)
    );

    always_comb begin
        t_d = t_q;
        if (tck_r) begin
            t_d.st = next_of(t_q.st, tms_s);
            case (t_q.st)
                jtp_pkg::TS_CAP_IR: t_d.ir_shf = jtp_pkg::INSN_CAPTURE;
                jtp_pkg::TS_SHF_IR: t_d.ir_shf = {tdi_s, t_q.ir_shf[jtp_pkg::INSN_W-1:1]};
                jtp_pkg::TS_CAP_DR: begin
                    t_d.pass  = 1'b0;
                    t_d.ident = ident_val;
                end
                jtp_pkg::TS_SHF_DR: begin
                    t_d.pass  = tdi_s;
                    t_d.ident = {tdi_s, t_q.ident[jtp_pkg::IDENT_W-1:1]};
                end
                default: ; // pause and exit states hold the stages
            endcase
        end
        // outputs change on falling tck so the tester samples stable data
        if (tck_f) begin
            if (t_q.st == jtp_pkg::TS_UPD_IR) begin
                t_d.ir_cur = t_q.ir_shf;
            end
            t_d.tdo_oe_n = !(t_q.st == jtp_pkg::TS_SHF_IR || t_q.st == jtp_pkg::TS_SHF_DR);
            if (t_q.st == jtp_pkg::TS_SHF_IR) begin
                t_d.tdo = t_q.ir_shf[0];
            end else begin
                case (sel)
                    jtp_pkg::SEL_IDENT:    t_d.tdo = t_q.ident[0];
                    jtp_pkg::SEL_BOUNDARY: t_d.tdo = bnd_out;
                    default:               t_d.tdo = t_q.pass;
                endcase
            end
        end
        if (t_q.st == jtp_pkg::TS_RESET) begin
            t_d.ir_cur   = jtp_pkg::INSN_RESET_VAL;
            // a trst mid-shift must not leave tdo driven until the next tck fall
            t_d.tdo_oe_n = 1'b1;
        end
        // pin muxing: normal function unless a test instruction claims the pins
        t_d.active   = ext_test | high_z;
        t_d.pin_out  = ext_test ? bnd_upd : core_out;
        t_d.pin_oe_n = high_z ? {CELLS{1'b1}} : ext_test ? '0 : ~core_oe;
        t_d.core_in  = pin_in;
        if (!trst_s) begin
            t_d.st     = jtp_pkg::TS_RESET;
            t_d.ir_cur = jtp_pkg::INSN_RESET_VAL;
        end
    end

    // trst acts through its synchroniser; tap holds no reset from rst_n beyond a constant
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            t_q          <= '0;
            t_q.st       <= jtp_pkg::TS_RESET;
            t_q.ir_cur   <= jtp_pkg::INSN_RESET_VAL;
            t_q.tdo_oe_n <= 1'b1;
            t_q.pin_oe_n <= '1;
        end else begin
            t_q <= t_d;
        end
    end

    assign tdo         = t_q.tdo;
    assign tdo_oe_n    = t_q.tdo_oe_n;
    assign pin_out     = t_q.pin_out;
    assign pin_oe_n    = t_q.pin_oe_n;
    assign core_in     = t_q.core_in;
    assign test_active = t_q.active;
endmodule

// ### jtp_pkg.sv
/*
 * shared constants and types for the test access port block.
 * assumes a single 50 MHz system clock; test pins are asynchronous to it.
 */
package jtp_pkg;

    // ------------------------------------------------------------
    // tap controller states
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        TS_RESET, TS_IDLE, TS_SEL_DR, TS_CAP_DR, TS_SHF_DR, TS_EX1_DR, TS_PAU_DR, TS_EX2_DR, TS_UPD_DR,
        TS_SEL_IR, TS_CAP_IR, TS_SHF_IR, TS_EX1_IR, TS_PAU_IR, TS_EX2_IR, TS_UPD_IR
    } jtp_state_t;

    // ------------------------------------------------------------
    // instruction codes and widths
    // ------------------------------------------------------------
    localparam int          INSN_W          = 4;
    localparam int          IDENT_W         = 32;
    localparam logic [3:0]  INSN_EXT_TEST   = 4'h0;
    localparam logic [3:0]  INSN_SAMPLE     = 4'h1;
    localparam logic [3:0]  INSN_IDENTIFY   = 4'h2;
    localparam logic [3:0]  INSN_HIGH_Z     = 4'h3;
    localparam logic [3:0]  INSN_PASSTHRU   = 4'hf;
    localparam logic [3:0]  INSN_CAPTURE    = 4'h1;
    localparam logic [3:0]  INSN_RESET_VAL  = INSN_IDENTIFY;

    // ------------------------------------------------------------
    // identification layout
    // ------------------------------------------------------------
    localparam int          ID_VER_LSB      = 28;
    localparam int          ID_PART_LSB     = 12;
    localparam int          ID_MFR_LSB      = 1;
    localparam logic        ID_FIXED_BIT    = 1'b1;

    // register selected by an instruction
    typedef enum logic [1:0] {
        SEL_PASSTHRU, SEL_BOUNDARY, SEL_IDENT
    } jtp_sel_t;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int          CLK_PERIOD_NS   = 20;
    localparam int          TRST_MIN_NS     = 50;
    localparam int          TRST_CYCLES     = (TRST_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage

// ### jtp_sync.sv
/*
 * two flop synchroniser plus rising/falling edge detect on the synced level.
 * assumes the input changes slowly compared with clock.
 */
`timescale 1ns/1ns
module jtp_sync (
    input  wire logic clock,
    input  wire logic rst_n,
    input  wire logic async_in,
    input  wire logic reset_val,
    output logic      level,
    output logic      rise,
    output logic      fall
);
    typedef struct packed {
        logic meta;
        logic sync;
        logic prev;
    } jtp_sync_st_t;

    jtp_sync_st_t s_q;
    jtp_sync_st_t s_d;

    always_comb begin
        s_d      = s_q;
        s_d.meta = async_in;
        s_d.sync = s_q.meta;
        s_d.prev = s_q.sync;
    end

    // every stage resets to zero whatever reset_val is, so trst comes up asserted
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign level = s_q.sync | (reset_val & 1'b0);
    assign rise  = s_q.sync & ~s_q.prev;
    assign fall  = ~s_q.sync & s_q.prev;
endmodule

// ### jtp_boundary.sv
/*
 * boundary scan chain: one cell per device pin, capture/shift/update stages.
 * assumes the tap module supplies one-cycle strobes on the system clock.
 */
`timescale 1ns/1ns
module jtp_boundary #(
    parameter int CELLS = 8
) (
    input  wire logic             clock,
    input  wire logic             rst_n,
    input  wire logic             cap_en,
    input  wire logic             shf_en,
    input  wire logic             upd_en,
    input  wire logic             ser_in,
    input  wire logic [CELLS-1:0] pin_sample,
    output logic                  ser_out,
    output logic      [CELLS-1:0] upd_val
);
    typedef struct packed {
        logic [CELLS-1:0] shf;
        logic [CELLS-1:0] upd;
    } jtp_bnd_st_t;

    jtp_bnd_st_t b_q;
    jtp_bnd_st_t b_d;

    always_comb begin
        b_d = b_q;
        if (cap_en) begin
            b_d.shf = pin_sample;
        end else if (shf_en) begin
            b_d.shf = {ser_in, b_q.shf[CELLS-1:1]};
        end
        if (upd_en) begin
            b_d.upd = b_q.shf;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            b_q <= '0;
        end else begin
            b_q <= b_d;
        end
    end

    assign ser_out = b_q.shf[0];
    assign upd_val = b_q.upd;
endmodule

// ### jtp_tap_sva.sv
/* assertion checker for the tap top ports.
   assumes tck edges at least 4 clocks apart; bound at the foot. */
`timescale 1ns/1ns
module jtp_tap_sva #(
    parameter int CELLS = 8
) (
    input wire logic             clock,
    input wire logic             rst_n,
    input wire logic             tck,
    input wire logic             tms,
    input wire logic             tdi,
    input wire logic             trst_n,
    input wire logic [CELLS-1:0] core_out,
    input wire logic [CELLS-1:0] core_oe,
    input wire logic [CELLS-1:0] pin_in,
    input wire logic             tdo,
    input wire logic             tdo_oe_n,
    input wire logic [CELLS-1:0] pin_out,
    input wire logic [CELLS-1:0] pin_oe_n,
    input wire logic [CELLS-1:0] core_in,
    input wire logic             test_active
);
    // ------------------------------------------------------------
    // helpers: clocks since tck moved, run of tms-high rises
    // ------------------------------------------------------------
    logic [3:0] q_cnt_q;
    logic [2:0] hi_cnt_q;
    logic       tms_q;
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            q_cnt_q  <= 4'h0;
            hi_cnt_q <= 3'h0;
            tms_q    <= 1'b1;
        end else begin
            if ($changed(tck) || !trst_n) begin
                q_cnt_q <= 4'h0;
            end else if (q_cnt_q != 4'hf) begin
                q_cnt_q <= q_cnt_q + 4'h1;
            end
            if ($rose(tck)) begin
                tms_q    <= tms;
                hi_cnt_q <= !tms ? 3'h0 : hi_cnt_q + {2'h0, hi_cnt_q != 3'h7};
            end
        end
    end
    default clocking @(posedge clock);
    endclocking
    default disable iff (!rst_n);
    // sync latency allows up to 4 clocks, 7 leaves margin
    a_tdo_on_fall: assert property ($changed(tdo) |-> q_cnt_q <= 4'h7)
        else $error("tdo moved with tck still");
    a_oe_on_edge: assert property ($changed(tdo_oe_n) |-> q_cnt_q <= 4'h7)
        else $error("tdo enable moved with tck still");
    a_active_on_edge: assert property ($changed(test_active) |-> q_cnt_q <= 4'h7)
        else $error("test mode moved with tck still");
    a_shift_tms_low: assert property ($fell(tdo_oe_n) |-> !tms_q)
        else $error("shift entered with tms high");
    a_five_high: assert property (hi_cnt_q >= 3'h5 && q_cnt_q >= 4'h6 |-> !test_active && tdo_oe_n)
        else $error("five tms-high edges did not reset");
    a_trst_forces: assert property (!trst_n [*6] |-> !test_active && tdo_oe_n)
        else $error("trst did not reset");
    a_core_in_follow: assert property ($past(rst_n) |-> core_in == $past(pin_in))
        else $error("core input not following pin");
    a_pins_follow: assert property ($past(rst_n) && !test_active && !$past(test_active)
        && !$past(test_active, 2) |-> pin_out == $past(core_out) && pin_oe_n == ~$past(core_oe))
        else $error("pins not following core");
endmodule
bind jtp_tap jtp_tap_sva #(.CELLS(CELLS)) u_sva (
    .clock(clock), .rst_n(rst_n), .tck(tck), .tms(tms), .tdi(tdi), .trst_n(trst_n),
    .core_out(core_out), .core_oe(core_oe), .pin_in(pin_in), .tdo(tdo), .tdo_oe_n(tdo_oe_n),
    .pin_out(pin_out), .pin_oe_n(pin_oe_n), .core_in(core_in), .test_active(test_active));

// ### jtp_ctrl_model.sv
/* behavioural test controller driving the tap pins.
   assumes the bench calls one task at a time; tck period 160 ns. */
`timescale 1ns/1ns
module jtp_ctrl_model (
    input  wire logic clock,
    input  wire logic tdo,
    output logic      tck,
    output logic      tms,
    output logic      tdi,
    output logic      trst_n
);
    // ------------------------------------------------------------
    // one tck period: fall, set pins, rise, sample tdo
    // ------------------------------------------------------------
    initial begin
        tck    = 1'b0;
        tms    = 1'b1;
        tdi    = 1'b1;
        trst_n = 1'b1;
    end
    task automatic cyc(input logic m, input logic d, output logic o);
        @(negedge clock);
        tck = 1'b0;
        repeat (2) @(negedge clock);
        tms = m;
        tdi = d;
        repeat (2) @(negedge clock);
        tck = 1'b1;
        repeat (2) @(negedge clock);
        o = tdo;
        @(negedge clock);
    endtask
    // tap also resets on rst_n; this walks it to reset with five tms-high edges, then to idle
    task automatic go_reset();
        logic o;
        repeat (5) cyc(1'b1, 1'b1, o);
        repeat (8) @(negedge clock);
        cyc(1'b0, 1'b1, o);
    endtask
    task automatic pulse_trst();
        logic o;
        trst_n = 1'b0;
        repeat (8) @(negedge clock);
        trst_n = 1'b1;
        repeat (4) @(negedge clock);
        cyc(1'b0, 1'b1, o);
    endtask
    // from idle; pause_at below zero means no pause
    task automatic scan(input logic ir, input int n, input int pause_at,
                        input logic [63:0] din, output logic [63:0] dout);
        logic o;
        dout = '0;
        cyc(1'b1, 1'b1, o);
        if (ir) begin
            cyc(1'b1, 1'b1, o);
        end
        repeat (2) cyc(1'b0, 1'b1, o);
        for (int i = 0; i < n; i++) begin
            cyc(i == n - 1 || i == pause_at, din[i], o);
            dout[i] = o;
            if (i == pause_at) begin
                repeat (2) cyc(1'b0, 1'b1, o);
                cyc(1'b1, 1'b1, o);
                cyc(1'b0, 1'b1, o);
            end
        end
        cyc(1'b1, 1'b1, o);
        cyc(1'b0, 1'b1, o);
    endtask
endmodule

// ### testbench.sv
/* self-checking bench for the test access port.
   assumes the controller model and the bound checker. */
`timescale 1ns/1ns
module testbench;
    logic        clock;
    logic        rst_n;
    logic        tck, tms, tdi, trst_n, tdo, tdo_oe_n, test_active;
    logic [7:0]  core_out, core_oe, pin_in, pin_out, pin_oe_n, core_in;
    logic [63:0] dq;
    int          n_mismatch;
    int          num_checks;
    int          cycles;
    // identity fields are arbitrary
    localparam logic [31:0] ID_EXP = {4'h3, 16'h5a6c, 11'h2b1, 1'b1};

    jtp_tap #(.CELLS(8), .ID_VERSION(4'h3), .ID_PART(16'h5a6c), .ID_MAKER(11'h2b1)) dut (
        .clock(clock), .rst_n(rst_n), .tck(tck), .tms(tms), .tdi(tdi), .trst_n(trst_n),
        .core_out(core_out), .core_oe(core_oe), .pin_in(pin_in), .tdo(tdo), .tdo_oe_n(tdo_oe_n),
        .pin_out(pin_out), .pin_oe_n(pin_oe_n), .core_in(core_in), .test_active(test_active));
    jtp_ctrl_model ctl (.clock(clock), .tdo(tdo), .tck(tck), .tms(tms), .tdi(tdi), .trst_n(trst_n));

    // ------------------------------------------------------------
    // clock, watchdog, checking
    // ------------------------------------------------------------
    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end
    always @(posedge clock) begin
        cycles++;
        if (cycles == 30000) begin
            n_mismatch++;
            summarize();
        end
    end
    task automatic summarize();
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic load_ir(input logic [3:0] code, input int pause_at);
        ctl.scan(1'b1, 4, pause_at, {60'h0, code}, dq);
        chk("ir capture", dq, {60'h0, jtp_pkg::INSN_CAPTURE});
    endtask
    task automatic t_identity();
        ctl.scan(1'b0, 32, 9, '1, dq);
        chk("identity", dq, {32'h0, ID_EXP});
        load_ir(jtp_pkg::INSN_IDENTIFY, 1);
        ctl.scan(1'b0, 32, -1, 64'h0, dq);
        chk("identity again", dq, {32'h0, ID_EXP});
    endtask
    task automatic t_passthru();
        logic [3:0] codes [5] = '{4'hf, 4'h3, 4'h4, 4'h9, 4'he};
        foreach (codes[k]) begin
            load_ir(codes[k], -1);
            ctl.scan(1'b0, 8, -1, 64'h5b, dq);
            chk("passthru", dq, 64'hb6);
            chk("active", {63'h0, test_active}, {63'h0, codes[k] == jtp_pkg::INSN_HIGH_Z});
            if (codes[k] == jtp_pkg::INSN_HIGH_Z) begin
                chk("pins off", {56'h0, pin_oe_n}, 64'hff);
            end else begin
                chk("pins", {48'h0, pin_oe_n, pin_out}, {48'h0, ~core_oe, core_out});
            end
        end
    endtask
    task automatic t_boundary();
        load_ir(jtp_pkg::INSN_SAMPLE, -1);
        ctl.scan(1'b0, 8, 3, 64'h69, dq);
        chk("sample", dq, {56'h0, core_out});
        load_ir(jtp_pkg::INSN_EXT_TEST, -1);
        chk("preload", {47'h0, test_active, pin_oe_n, pin_out}, {47'h0, 1'b1, 8'h00, 8'h69});
        pin_in = 8'hc3;
        ctl.scan(1'b0, 8, -1, 64'h0, dq);
        chk("ext capture", dq, 64'hc3);
        chk("ext drive", {56'h0, pin_out}, 64'h0);
        chk("core in", {56'h0, core_in}, 64'hc3);
        ctl.go_reset();
        chk("tms reset", {55'h0, test_active, pin_out}, {55'h0, 1'b0, core_out});
    endtask
    task automatic t_trst();
        load_ir(jtp_pkg::INSN_EXT_TEST, -1);
        ctl.pulse_trst();
        chk("trst", {63'h0, test_active}, 64'h0);
        chk("tdo idle", {63'h0, tdo_oe_n}, 64'h1);
        ctl.scan(1'b0, 32, -1, 64'h0, dq);
        chk("identity after trst", dq, {32'h0, ID_EXP});
    endtask
    initial begin
        rst_n = 1'b0;
        core_out = 8'ha5;
        core_oe = 8'h3c;
        pin_in = 8'h96;
        repeat (8) @(negedge clock);
        rst_n = 1'b1;
        repeat (4) @(negedge clock);
        ctl.go_reset();
        t_identity();
        t_passthru();
        t_boundary();
        t_trst();
        summarize();
    end
endmodule
